// file: inc/sdw_pkg.sv
// Purpose: shared constants for the serial dac write decoder
// Assumes: 16-bit frames, msb first, data sampled on rising serial clock
// Notes:   field positions are frame bit indices
package sdw_pkg;
    localparam int FRAME_BITS     = 16;
    localparam int CODE_BITS      = 12;
    localparam int BIT_IGNORE     = 15;
    localparam int BIT_BUFFERED   = 14;
    localparam int BIT_GAIN_N     = 13;
    localparam int BIT_ACTIVE_N   = 12;
    localparam int CODE_MSB       = 11;
    localparam int RES_12         = 12;
    localparam int RES_10         = 10;
    localparam int RES_8          = 8;
    // power-on values of the output register: shutdown, 2x gain, unbuffered
    localparam logic RST_BUFFERED = 1'b0;
    localparam logic RST_GAIN_N   = 1'b0;
    localparam logic RST_ACTIVE   = 1'b0;
    localparam logic [11:0] RST_CODE = 12'h000;
    localparam int SYNC_STAGES    = 2;
endpackage

// file: src/sdw_sync.sv
// Purpose: two-flop synchroniser for one input pin
// Assumes: reset value given by parameter
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module sdw_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and control
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_ce,
    // pin in, synchronised out
    input  wire logic i_async,
    output var  logic o_sync
);
    logic meta;
    logic next_meta;
    logic next_sync;

    always_comb begin
        next_meta = meta;
        next_sync = o_sync;
        if (i_reset) begin
            next_meta = RST_VAL;
            next_sync = RST_VAL;
        end else if (i_ce) begin
            next_meta = i_async;
            next_sync = meta;
        end
    end

    always_ff @(posedge i_clk) begin
        meta   <= next_meta;
        o_sync <= next_sync;
    end
endmodule
`default_nettype wire

// file: src/sdw_decoder.sv
// Purpose: write-only serial command decoder for a single-channel dac
// Assumes: pins are asynchronous; serial clock much slower than i_clk
// Notes:   no readback path exists; outputs feed the analog stage
//          serial clock halves and chip select high time must span three clocks or more
`timescale 1ns/1ps
`default_nettype none
module sdw_decoder
    import sdw_pkg::*;
#(
    parameter int RESOLUTION = sdw_pkg::RES_12
) (
    // clock, reset, enable
    input  wire logic                        i_clk,
    input  wire logic                        i_reset,
    input  wire logic                        i_ce,
    // serial link pins
    input  wire logic                        i_cs_n,
    input  wire logic                        i_sck,
    input  wire logic                        i_sdi,
    input  wire logic                        i_output_load_n,
    // analog stage controls
    output var  logic                        o_ref_buffered,
    output var  logic                        o_gain_select_n,
    output var  logic                        o_output_active,
    output var  logic [sdw_pkg::CODE_BITS-1:0] o_dac_code,
    output var  logic                        o_output_update
);
    import sdw_pkg::*;

    // only the three supported resolutions have a code mask
    if (RESOLUTION != RES_12 && RESOLUTION != RES_10 && RESOLUTION != RES_8) begin : g_bad_resolution
        $error("RESOLUTION must be 8, 10 or 12");
    end

    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FRAME_BITS);

    // synchronised pins
    logic cs_n_s;
    logic sck_s;
    logic sdi_s;
    logic load_n_s;

    // reset values match the idle pin levels so no false edge follows reset
    sdw_sync #(
        .RST_VAL (1'b1)
    ) u_sync_cs (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async (i_cs_n),
        .o_sync  (cs_n_s)
    );
    sdw_sync #(
        .RST_VAL (1'b0)
    ) u_sync_sck (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async (i_sck),
        .o_sync  (sck_s)
    );
    sdw_sync #(
        .RST_VAL (1'b0)
    ) u_sync_sdi (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async (i_sdi),
        .o_sync  (sdi_s)
    );
    sdw_sync #(
        .RST_VAL (1'b1)
    ) u_sync_load (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_async (i_output_load_n),
        .o_sync  (load_n_s)
    );

    // receiver state
    logic                  sck_d;
    logic                  cs_n_d;
    logic [FRAME_BITS-1:0] shift;
    logic [CNT_W-1:0]      bit_cnt;
    // input register
    logic                  in_valid;
    logic                  in_buffered;
    logic                  in_gain_n;
    logic                  in_active;
    logic [CODE_BITS-1:0]  in_code;

    logic                  next_sck_d;
    logic                  next_cs_n_d;
    logic [FRAME_BITS-1:0] next_shift;
    logic [CNT_W-1:0]      next_bit_cnt;
    logic                  next_in_valid;
    logic                  next_in_buffered;
    logic                  next_in_gain_n;
    logic                  next_in_active;
    logic [CODE_BITS-1:0]  next_in_code;
    logic                  next_ref_buffered;
    logic                  next_gain_select_n;
    logic                  next_output_active;
    logic [CODE_BITS-1:0]  next_dac_code;
    logic                  next_output_update;

    logic sck_rise;
    logic cs_rise;
    logic frame_ok;
    logic [CODE_BITS-1:0] masked_code;

    assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
    assign cs_rise  = cs_n_s & ~cs_n_d;
    assign frame_ok = cs_rise && (bit_cnt == FULL_CNT) && !shift[BIT_IGNORE];
    // unused low bits are cleared so the code stays left-justified
    assign masked_code = shift[CODE_MSB:0] &
                         ~(CODE_BITS'((1 << (CODE_BITS - RESOLUTION)) - 1));

    // receiver: edge detectors, shift register and bit counter
    always_comb begin
        next_sck_d   = sck_d;
        next_cs_n_d  = cs_n_d;
        next_shift   = shift;
        next_bit_cnt = bit_cnt;
        if (i_reset) begin
            next_sck_d   = 1'b0;
            next_cs_n_d  = 1'b1;
            next_shift   = '0;
            next_bit_cnt = '0;
        end else if (i_ce) begin
            next_sck_d  = sck_s;
            next_cs_n_d = cs_n_s;
            // shift only while selected and below sixteen bits
            if (cs_n_s) begin
                next_bit_cnt = '0;
            end else if (sck_rise && bit_cnt != FULL_CNT) begin
                next_shift   = {shift[FRAME_BITS-2:0], sdi_s};
                next_bit_cnt = bit_cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        sck_d   <= next_sck_d;
        cs_n_d  <= next_cs_n_d;
        shift   <= next_shift;
        bit_cnt <= next_bit_cnt;
    end

    // input register loads only on a good frame
    always_comb begin
        next_in_valid    = in_valid;
        next_in_buffered = in_buffered;
        next_in_gain_n   = in_gain_n;
        next_in_active   = in_active;
        next_in_code     = in_code;
        if (i_reset) begin
            next_in_valid    = 1'b0;
            next_in_buffered = RST_BUFFERED;
            next_in_gain_n   = RST_GAIN_N;
            next_in_active   = RST_ACTIVE;
            next_in_code     = RST_CODE;
        end else if (i_ce && frame_ok) begin
            next_in_valid    = 1'b1;
            next_in_buffered = shift[BIT_BUFFERED];
            next_in_gain_n   = shift[BIT_GAIN_N];
            next_in_active   = shift[BIT_ACTIVE_N];
            next_in_code     = masked_code;
        end
    end

    always_ff @(posedge i_clk) begin
        in_valid    <= next_in_valid;
        in_buffered <= next_in_buffered;
        in_gain_n   <= next_in_gain_n;
        in_active   <= next_in_active;
        in_code     <= next_in_code;
    end

    // output register: level-sensitive transfer, a held-low load tracks each new frame
    always_comb begin
        next_ref_buffered  = o_ref_buffered;
        next_gain_select_n = o_gain_select_n;
        next_output_active = o_output_active;
        next_dac_code      = o_dac_code;
        next_output_update = 1'b0;
        if (i_reset) begin
            next_ref_buffered  = RST_BUFFERED;
            next_gain_select_n = RST_GAIN_N;
            next_output_active = RST_ACTIVE;
            next_dac_code      = RST_CODE;
        end else if (i_ce && !load_n_s && in_valid) begin
            next_ref_buffered  = in_buffered;
            next_gain_select_n = in_gain_n;
            next_output_active = in_active;
            next_dac_code      = in_code;
            // pulse only on a real change, so a held load gives one pulse per new frame that changes an output
            next_output_update = (in_buffered != o_ref_buffered) ||
                                 (in_gain_n != o_gain_select_n) ||
                                 (in_active != o_output_active) ||
                                 (in_code != o_dac_code);
        end
    end

    always_ff @(posedge i_clk) begin
        o_ref_buffered  <= next_ref_buffered;
        o_gain_select_n <= next_gain_select_n;
        o_output_active <= next_output_active;
        o_dac_code      <= next_dac_code;
        o_output_update <= next_output_update;
    end
endmodule
`default_nettype wire

// file: tb/sdw_props.sv
// Purpose: checker for the decoder output register and update pulse
// Assumes: clock enable held high by the bench
// Notes:   the frame age saturates so long idle spans stay legal
`timescale 1ns/1ps
`default_nettype none
module sdw_props #(
    parameter int RESOLUTION = 12
) (
    // clock and control
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    // link pins
    input  wire logic        i_cs_n,
    input  wire logic        i_sck,
    input  wire logic        i_sdi,
    input  wire logic        i_output_load_n,
    // analog stage controls
    input  wire logic        o_ref_buffered,
    input  wire logic        o_gain_select_n,
    input  wire logic        o_output_active,
    input  wire logic [11:0] o_dac_code,
    input  wire logic        o_output_update
);
    localparam logic [11:0] LOW_MASK = 12'((1 << (12 - RESOLUTION)) - 1);
    logic [14:0] outs;
    logic        cs_n_q;
    logic [7:0]  cs_age;
    logic [7:0]  next_cs_age;
    assign outs = {o_ref_buffered, o_gain_select_n, o_output_active, o_dac_code};
    always_comb begin
        next_cs_age = (cs_age == 8'hFF) ? cs_age : cs_age + 8'h01;
        if (i_cs_n && !cs_n_q) begin
            next_cs_age = 8'h00;
        end
    end
    always_ff @(posedge i_clk) begin
        cs_n_q <= i_cs_n;
        cs_age <= i_reset ? 8'hFF : next_cs_age;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_change_flagged; $changed(outs) |-> o_output_update; endproperty
    property p_load_gate;
        o_output_update |-> !($past(i_output_load_n, 2) && $past(i_output_load_n, 3) && $past(i_output_load_n, 4));
    endproperty
    property p_quiet_load_high; i_output_load_n [*5] |-> $stable(outs); endproperty
    property p_low_bits; (o_dac_code & LOW_MASK) == 12'h000; endproperty
    property p_reset_state; $fell(i_reset) |-> outs == 15'h0000 && !o_output_update; endproperty
    property p_frame_update;
        (!i_output_load_n) [*8] ##0 o_output_update |-> cs_age >= 8'h01 && cs_age <= 8'h07;
    endproperty
    property p_single_pulse; o_output_update |=> !o_output_update; endproperty
    property p_wake_flagged; $rose(o_output_active) |-> o_output_update; endproperty
    a_change_flagged: assert property (p_change_flagged) else $error("outputs moved without update");
    a_load_gate: assert property (p_load_gate) else $error("update without low load pin");
    a_quiet_load_high: assert property (p_quiet_load_high) else $error("outputs moved, load high");
    a_low_bits: assert property (p_low_bits) else $error("unused code bits not zero");
    a_reset_state: assert property (p_reset_state) else $error("outputs not in shutdown after reset");
    a_frame_update: assert property (p_frame_update) else $error("held load update not after frame");
    a_single_pulse: assert property (p_single_pulse) else $error("update pulse too long");
    a_wake_flagged: assert property (p_wake_flagged) else $error("wake without update");
    c_update: cover property (o_output_update);
    c_wake: cover property ($rose(o_output_active));
    c_sleep: cover property ($fell(o_output_active));
endmodule
bind sdw_decoder sdw_props #(.RESOLUTION(RESOLUTION)) u_props (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_cs_n(i_cs_n), .i_sck(i_sck), .i_sdi(i_sdi), .i_output_load_n(i_output_load_n),
    .o_ref_buffered(o_ref_buffered), .o_gain_select_n(o_gain_select_n), .o_output_active(o_output_active),
    .o_dac_code(o_dac_code), .o_output_update(o_output_update));
`default_nettype wire

// file: tb/sdw_host.sv
// Purpose: host serial driver for the write decoder link
// Assumes: serial clock idles low, data changes while it is low
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module sdw_host (
    // clock
    input  wire logic i_clk,
    // serial link
    output var  logic o_cs_n,
    output var  logic o_sck,
    output var  logic o_sdi
);
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_sdi  = 1'b0;
    end
    // fewer than 16 clocks aborts, more adds clocks to be ignored
    task automatic send(input logic [15:0] frame, input int nbits);
        o_cs_n <= 1'b0;
        // 200 ns serial clock: data set on each falling edge, four clocks before the rise
        for (int i = 0; i < nbits; i++) begin
            o_sdi <= (i < 16) ? frame[15 - i] : ~o_sdi;
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_sdi  <= ~o_sdi;
        repeat (8) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/serial_dac_write_decoder_tb_top.sv
// Purpose: directed bench for the 10-bit and 8-bit decoder variants on one link
// Assumes: clock enable tied high
// Notes:   expected outputs are the frame fields with the unused low code bits cleared
`timescale 1ns/1ps
`default_nettype none
module serial_dac_write_decoder_tb_top;
    logic        i_clk;
    logic        i_reset;
    logic        load_n;
    wire         cs_n;
    wire         sck;
    wire         sdi;
    wire  [14:0] outs;
    wire         upd;
    wire  [14:0] outs8;
    wire         upd8;
    int          n_fail;
    int          checked;
    int          cycles;
    int          n_upd;
    int          n_upd8;
    sdw_host host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi));
    sdw_decoder #(.RESOLUTION(10)) dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_cs_n(cs_n),
        .i_sck(sck), .i_sdi(sdi), .i_output_load_n(load_n), .o_ref_buffered(outs[14]),
        .o_gain_select_n(outs[13]), .o_output_active(outs[12]), .o_dac_code(outs[11:0]),
        .o_output_update(upd));
    sdw_decoder #(.RESOLUTION(8)) dut_8 (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_cs_n(cs_n),
        .i_sck(sck), .i_sdi(sdi), .i_output_load_n(load_n), .o_ref_buffered(outs8[14]),
        .o_gain_select_n(outs8[13]), .o_output_active(outs8[12]), .o_dac_code(outs8[11:0]),
        .o_output_update(upd8));
    // update pulses of each variant, one count per registered pulse
    always @(posedge i_clk) begin
        if (upd === 1'b1) n_upd <= n_upd + 1;
        if (upd8 === 1'b1) n_upd8 <= n_upd8 + 1;
    end
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // outputs are looked at mid-cycle, away from the edge that launches them
    task automatic check(input logic [15:0] frame);
        logic [14:0] exp10;
        logic [14:0] exp8;
        exp10 = frame[14:0] & 15'h7FFC;
        exp8  = frame[14:0] & 15'h7FF0;
        @(negedge i_clk);
        checked++;
        if (outs !== exp10 || outs8 !== exp8) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h/%h exp=%h/%h", $time, outs, outs8, exp10, exp8);
        end
        @(posedge i_clk);
    endtask
    task automatic check_upd(input int exp);
        @(negedge i_clk);
        checked++;
        if (n_upd != exp || n_upd8 != exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h/%h exp=%h", $time, n_upd, n_upd8, exp);
        end
        @(posedge i_clk);
    endtask
    task automatic conclude();
        if (n_fail == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        i_reset = 1'b1;
        load_n  = 1'b1;
        n_fail  = 0;
        checked = 0;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_clk);
        check(16'h0000);
        host.send(16'h72A7, 16);
        check(16'h0000);
        load_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        load_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        check(16'h72A7);
        check_upd(1);
        host.send(16'hF5A5, 16);
        host.send(16'h0000, 12);
        load_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        check(16'h72A7);
        check_upd(1);
        host.send(16'h0C35, 19);
        repeat (10) @(posedge i_clk);
        check(16'h0C35);
        host.send(16'h37FD, 16);
        repeat (10) @(posedge i_clk);
        check(16'h37FD);
        check_upd(3);
        conclude();
    end
endmodule
`default_nettype wire
